/* pkg/spcg_pkg.sv */
package spcg_pkg;

  // ----------------------------------------
  // Sizes and register map
  // ----------------------------------------
  localparam int SPCG_NUM_PORTS = 8;
  localparam int SPCG_ADDR_WIDTH = 12;
  localparam int SPCG_INDEX_WIDTH = 3;
  localparam logic [11:0] SPCG_SLEEP_GATES_OFFSET = 12'h118;
  localparam logic [11:0] SPCG_INT_STATUS_OFFSET = 12'h200;
  localparam logic [11:0] SPCG_INT_MASK_OFFSET = 12'h204;
  localparam logic [11:0] SPCG_GATE_STATUS_OFFSET = 12'h208;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int SPCG_GATE_LSB = 0;
  localparam int SPCG_GATE_MSB = 7;
  localparam int SPCG_INT_WIDTH = 2;
  localparam int SPCG_INT_FAULT_BIT = 0;
  localparam int SPCG_INT_CHANGE_BIT = 1;
  localparam int SPCG_STAT_MODE_LSB = 8;
  localparam int SPCG_STAT_SELECT_BIT = 10;
  localparam logic [31:0] SPCG_SLEEP_GATES_RESET = 32'h0000_0000;
  localparam logic [7:0] SPCG_ENABLES_RESET = 8'h00;
  localparam logic [1:0] SPCG_INT_RESET = 2'h0;
  localparam logic [31:0] SPCG_READ_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SPCG_MODE_RUN,
    SPCG_MODE_SLEEP,
    SPCG_MODE_DEEP
  } spcg_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [SPCG_ADDR_WIDTH-1:0] paddr;
    logic [31:0] pwdata;
  } spcg_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } spcg_apb_rsp_t;

  typedef struct packed {
    logic [SPCG_NUM_PORTS-1:0] sleepGates;
    logic [SPCG_NUM_PORTS-1:0] enables;
    spcg_mode_t mode;
    logic [SPCG_INT_WIDTH-1:0] intStatus;
    logic [SPCG_INT_WIDTH-1:0] intMask;
    logic [31:0] readData;
  } spcg_state_t;

endpackage

/* src/spcg_fault_check.sv */
`timescale 1ns/10ps
`default_nettype none
module spcg_fault_check
  import spcg_pkg::*;
#(
  parameter int NumPorts = SPCG_NUM_PORTS,
  parameter int IndexWidth = SPCG_INDEX_WIDTH
) (
  // Current clock enables.
  input wire logic [NumPorts-1:0] portEnables,
  // Access from the system bus to one port.
  input wire logic portAccess,
  input wire logic [IndexWidth-1:0] portIndex,
  // Decision on that access.
  output logic portBusFault,
  output logic portGrant
);

  logic [NumPorts-1:0] faultVec;

  // An access to a port without clock faults instead of completing.
  for (genvar i = 0; i < NumPorts; i++) begin : g_port
    assign faultVec[i] = portAccess && (portIndex == IndexWidth'(i)) && !portEnables[i];
  end

  assign portBusFault = |faultVec;
  assign portGrant = portAccess && !portBusFault;

endmodule
`default_nettype wire

/* src/spcg_gate_select.sv */
`timescale 1ns/10ps
`default_nettype none
module spcg_gate_select
  import spcg_pkg::*;
#(
  parameter int NumPorts = SPCG_NUM_PORTS
) (
  // Power state and gating select.
  input wire logic inSleep,
  input wire logic inDeepSleep,
  input wire logic autoSleepGatingSelect,
  // Candidate gate sets.
  input wire logic [NumPorts-1:0] runGates,
  input wire logic [NumPorts-1:0] sleepGates,
  input wire logic [NumPorts-1:0] deepGates,
  // Chosen set and the mode that chose it.
  output logic [NumPorts-1:0] selectedGates,
  output spcg_mode_t mode
);

  // Sleep sets apply only while automatic gating is selected.
  always_comb begin
    if (autoSleepGatingSelect && inDeepSleep) begin
      mode = SPCG_MODE_DEEP;
    end else if (autoSleepGatingSelect && inSleep) begin
      mode = SPCG_MODE_SLEEP;
    end else begin
      mode = SPCG_MODE_RUN;
    end
  end

  // Each port picks its enable from the set of the chosen mode.
  for (genvar i = 0; i < NumPorts; i++) begin : g_port
    assign selectedGates[i] = (mode == SPCG_MODE_DEEP) ? deepGates[i] :
                              (mode == SPCG_MODE_SLEEP) ? sleepGates[i] : runGates[i];
  end

endmodule
`default_nettype wire

/* src/spcg_sleep_gates.sv */
// Summary of operation
// R1: Each set gate bit clocks its port, which then works normally.
// R2: A cleared gate bit stops the port clock and keeps the port disabled.
// R3: Any access to a port without clock ends in a bus fault.
// R4: Reset loads the whole sleep gate register with zero.
// R5: Ports A to H map onto bits 0 to 7, read/write, reset zero.
// R6: Bits 31 to 8 read as zero and ignore writes.
// R7: Software keeps reserved bits by writing back what it read.
// R8: Sleep set rules in Sleep, run set when running, deep set in Deep-Sleep.
// R9: Sleep sets are used only while automatic gating select is set.
// R10: Without automatic gating select, the run set also governs Sleep.
`timescale 1ns/10ps
`default_nettype none
module spcg_sleep_gates
  import spcg_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Register bus.
  input wire spcg_apb_req_t apbReq,
  output spcg_apb_rsp_t apbRsp,
  // Power state and the other gate sets.
  input wire logic inSleep,
  input wire logic inDeepSleep,
  input wire logic autoSleepGatingSelect,
  input wire logic [SPCG_NUM_PORTS-1:0] runPortClockGates,
  input wire logic [SPCG_NUM_PORTS-1:0] deepSleepPortClockGates,
  // Port accesses from the system bus.
  input wire logic portAccess,
  input wire logic [SPCG_INDEX_WIDTH-1:0] portIndex,
  output logic portBusFault,
  output logic portGrant,
  // Clock enables to the port clock gate cells.
  output logic [SPCG_NUM_PORTS-1:0] portClockEnable,
  // Interrupt.
  output logic irq
);

  // ----------------------------------------
  // Decoding
  // ----------------------------------------

  // True when an aligned address hits a register offset.
  function automatic logic regHit(input logic [SPCG_ADDR_WIDTH-1:0] addr,
                                  input logic [SPCG_ADDR_WIDTH-1:0] offset);
    regHit = (addr[SPCG_ADDR_WIDTH-1:2] == offset[SPCG_ADDR_WIDTH-1:2]) && (addr[1:0] == 2'h0);
  endfunction

  spcg_state_t state;
  spcg_state_t next_state;
  logic [SPCG_NUM_PORTS-1:0] selectedGates;
  spcg_mode_t selectedMode;
  logic setupPhase;
  logic accessPhase;
  logic hitSleep;
  logic hitStatus;
  logic hitMask;
  logic hitGateStat;
  logic hitAny;
  logic writeAccess;
  logic [SPCG_INT_WIDTH-1:0] events;
  logic [31:0] readValue;

  // Bus phases and register hits.
  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessPhase = apbReq.psel && apbReq.penable;
  assign hitSleep = regHit(apbReq.paddr, SPCG_SLEEP_GATES_OFFSET);
  assign hitStatus = regHit(apbReq.paddr, SPCG_INT_STATUS_OFFSET);
  assign hitMask = regHit(apbReq.paddr, SPCG_INT_MASK_OFFSET);
  assign hitGateStat = regHit(apbReq.paddr, SPCG_GATE_STATUS_OFFSET);
  assign hitAny = hitSleep || hitStatus || hitMask || hitGateStat;
  assign writeAccess = accessPhase && apbReq.pwrite && hitAny;

  // ----------------------------------------
  // Gate selection and fault check
  // ----------------------------------------

  // Chooses the gate set that the power state calls for.
  spcg_gate_select #(
    .NumPorts(SPCG_NUM_PORTS)
  ) u_select (
    .inSleep(inSleep),
    .inDeepSleep(inDeepSleep),
    .autoSleepGatingSelect(autoSleepGatingSelect),
    .runGates(runPortClockGates),
    .sleepGates(state.sleepGates),
    .deepGates(deepSleepPortClockGates),
    .selectedGates(selectedGates),
    .mode(selectedMode)
  );

  // Faults accesses to ports whose clock is off.
  spcg_fault_check #(
    .NumPorts(SPCG_NUM_PORTS),
    .IndexWidth(SPCG_INDEX_WIDTH)
  ) u_fault (
    .portEnables(state.enables),
    .portAccess(portAccess),
    .portIndex(portIndex),
    .portBusFault(portBusFault), // [R3]
    .portGrant(portGrant)
  );

  // Events that set sticky status bits.
  always_comb begin
    events = SPCG_INT_RESET;
    events[SPCG_INT_FAULT_BIT] = portBusFault;
    events[SPCG_INT_CHANGE_BIT] = (selectedGates != state.enables);
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------

  // Reserved bits of every register read as zero.
  always_comb begin
    readValue = SPCG_READ_RESET;
    if (hitSleep) begin
      readValue[SPCG_GATE_MSB:SPCG_GATE_LSB] = state.sleepGates; // [R5] [R6]
    end else if (hitStatus) begin
      readValue[SPCG_INT_WIDTH-1:0] = state.intStatus;
    end else if (hitMask) begin
      readValue[SPCG_INT_WIDTH-1:0] = state.intMask;
    end else if (hitGateStat) begin
      readValue[SPCG_GATE_MSB:SPCG_GATE_LSB] = state.enables;
      readValue[SPCG_STAT_MODE_LSB+1:SPCG_STAT_MODE_LSB] = state.mode;
      readValue[SPCG_STAT_SELECT_BIT] = autoSleepGatingSelect;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------

  // Register writes, sticky status and the applied enables.
  always_comb begin
    next_state = state;
    // The applied set follows the power state one cycle later.
    next_state.enables = selectedGates; // [R1] [R2] [R8] [R9] [R10]
    next_state.mode = selectedMode;
    // Read data is captured in the setup phase for a zero-wait access.
    if (setupPhase && !apbReq.pwrite) begin
      next_state.readData = readValue;
    end
    if (writeAccess && hitSleep) begin
      // Only the low eight bits store; the rest are dropped.
      next_state.sleepGates = apbReq.pwdata[SPCG_GATE_MSB:SPCG_GATE_LSB]; // [R5] [R6]
    end
    if (writeAccess && hitMask) begin
      next_state.intMask = apbReq.pwdata[SPCG_INT_WIDTH-1:0];
    end
    if (writeAccess && hitStatus) begin
      next_state.intStatus = state.intStatus & ~apbReq.pwdata[SPCG_INT_WIDTH-1:0];
    end
    // A new event wins over a clear in the same cycle.
    next_state.intStatus = next_state.intStatus | events;
  end

  // State register with synchronous reset.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state.sleepGates <= SPCG_SLEEP_GATES_RESET[SPCG_GATE_MSB:SPCG_GATE_LSB]; // [R4]
      state.enables <= SPCG_ENABLES_RESET;
      state.mode <= SPCG_MODE_RUN;
      state.intStatus <= SPCG_INT_RESET;
      state.intMask <= SPCG_INT_RESET;
      state.readData <= SPCG_READ_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Zero-wait slave; unmapped or misaligned addresses answer with an error.
  assign apbRsp = '{
    prdata: state.readData,
    pready: accessPhase,
    pslverr: accessPhase && !hitAny
  };

  // The clock enables drive each port's gate cell and enable.
  assign portClockEnable = state.enables;

  // Level interrupt while any unmasked status bit is set.
  assign irq = |(state.intStatus & state.intMask);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  // Reset clears the sleep gates and the clock enables.
  property p_reset_clear;
    @(posedge clock) !rst_n |=> (state.sleepGates == SPCG_ENABLES_RESET) && (portClockEnable == SPCG_ENABLES_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Gates not zero after reset."); // [R4]

  // A write to the sleep register stores exactly the low eight bits.
  property p_write_gates;
    @(posedge clock) disable iff (!rst_n)
      (accessPhase && apbReq.pwrite && hitSleep)
      |=> state.sleepGates == $past(apbReq.pwdata[SPCG_GATE_MSB:SPCG_GATE_LSB]);
  endproperty
  a_write_gates: assert property (p_write_gates) else $error("Sleep gate write not stored."); // [R5]

  // Reading the sleep register shows zeros above bit seven.
  property p_reserved_zero;
    @(posedge clock) disable iff (!rst_n)
      (accessPhase && !apbReq.pwrite && hitSleep) |-> (apbRsp.prdata[31:8] == 24'h00_0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits read nonzero."); // [R6]

  // In Sleep with automatic gating the sleep set is applied next cycle.
  property p_sleep_apply;
    @(posedge clock) disable iff (!rst_n)
      (autoSleepGatingSelect && inSleep && !inDeepSleep) |=> portClockEnable == $past(state.sleepGates);
  endproperty
  a_sleep_apply: assert property (p_sleep_apply) else $error("Sleep set not applied."); // [R8]

  // In Deep-Sleep with automatic gating the deep set is applied.
  property p_deep_apply;
    @(posedge clock) disable iff (!rst_n)
      (autoSleepGatingSelect && inDeepSleep) |=> portClockEnable == $past(deepSleepPortClockGates);
  endproperty
  a_deep_apply: assert property (p_deep_apply) else $error("Deep set not applied."); // [R9]

  // Without automatic gating the run set is applied in every state.
  property p_run_apply;
    @(posedge clock) disable iff (!rst_n)
      !autoSleepGatingSelect |=> portClockEnable == $past(runPortClockGates);
  endproperty
  a_run_apply: assert property (p_run_apply) else $error("Run set not applied."); // [R10]

  // An access to a port without clock faults and is not granted.
  property p_fault;
    @(posedge clock) disable iff (!rst_n)
      (portAccess && !portClockEnable[portIndex]) |-> (portBusFault && !portGrant);
  endproperty
  a_fault: assert property (p_fault) else $error("Unclocked access not faulted."); // [R3]

  // An access to a clocked port is granted without fault.
  property p_clocked_ok;
    @(posedge clock) disable iff (!rst_n)
      (portAccess && portClockEnable[portIndex]) |-> (portGrant && !portBusFault);
  endproperty
  a_clocked_ok: assert property (p_clocked_ok) else $error("Clocked access faulted."); // [R1]

  // With all selected gates cleared for two cycles, no port is enabled or granted next cycle.
  property p_gate_off;
    @(posedge clock) disable iff (!rst_n)
      (selectedGates == SPCG_ENABLES_RESET) [*2] |=> (portClockEnable == SPCG_ENABLES_RESET) && !portGrant;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("Gated port still enabled."); // [R2]

  // A fault sets its sticky bit even during a clear.
  property p_fault_sticky;
    @(posedge clock) disable iff (!rst_n)
      portBusFault |=> state.intStatus[SPCG_INT_FAULT_BIT];
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("Fault status lost.");

  // ----------------------------------------
  // Register, interrupt and gate selection assertions
  // ----------------------------------------

  // A read of the sleep register returns the stored gates in the low byte.
  property p_read_gates;
    @(posedge clock) disable iff (!rst_n)
      (accessPhase && !apbReq.pwrite && hitSleep)
      |-> (apbRsp.prdata[SPCG_GATE_MSB:SPCG_GATE_LSB] == state.sleepGates);
  endproperty
  a_read_gates: assert property (p_read_gates) else $error("Sleep gate read wrong."); // [R5]

  // An unmapped read answers with an error and zero data.
  property p_unmapped_read;
    @(posedge clock) disable iff (!rst_n)
      (accessPhase && !apbReq.pwrite && !hitAny)
      |-> apbRsp.pslverr && (apbRsp.prdata == SPCG_READ_RESET);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not refused.");

  // An unmapped write changes neither the gates nor the mask.
  property p_unmapped_write;
    @(posedge clock) disable iff (!rst_n)
      (accessPhase && apbReq.pwrite && !hitAny)
      |=> $stable(state.sleepGates) && $stable(state.intMask);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("Unmapped write changed state.");

  // Writing a one clears the fault status when no fault arrives with it.
  property p_status_clear;
    @(posedge clock) disable iff (!rst_n)
      (writeAccess && hitStatus && apbReq.pwdata[SPCG_INT_FAULT_BIT] && !portBusFault)
      |=> !state.intStatus[SPCG_INT_FAULT_BIT];
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("Fault status not cleared.");

  // A change of the applied set raises the change status.
  property p_change_event;
    @(posedge clock) disable iff (!rst_n)
      (selectedGates != portClockEnable) |=> state.intStatus[SPCG_INT_CHANGE_BIT];
  endproperty
  a_change_event: assert property (p_change_event) else $error("Change status not set.");

  // A fault with its mask bit set raises the interrupt on the next cycle.
  property p_irq_fault;
    @(posedge clock) disable iff (!rst_n)
      (portBusFault && state.intMask[SPCG_INT_FAULT_BIT] && !(writeAccess && hitMask)) |=> irq;
  endproperty
  a_irq_fault: assert property (p_irq_fault) else $error("Fault interrupt missing."); // [R3]

  // Without automatic gating select the sleep register is never applied.
  property p_select_clear;
    @(posedge clock) disable iff (!rst_n)
      (!autoSleepGatingSelect && inSleep && (state.sleepGates != runPortClockGates))
      |=> portClockEnable != $past(state.sleepGates);
  endproperty
  a_select_clear: assert property (p_select_clear) else $error("Sleep set used without select."); // [R9]

  // Deep-Sleep wins over Sleep when both are signalled with select set.
  property p_deep_priority;
    @(posedge clock) disable iff (!rst_n)
      (autoSleepGatingSelect && inDeepSleep && inSleep) |=> state.mode == SPCG_MODE_DEEP;
  endproperty
  a_deep_priority: assert property (p_deep_priority) else $error("Deep-Sleep not chosen."); // [R8]

  // Without select the run mode is recorded whatever the power state.
  property p_mode_run;
    @(posedge clock) disable iff (!rst_n)
      !autoSleepGatingSelect |=> state.mode == SPCG_MODE_RUN;
  endproperty
  a_mode_run: assert property (p_mode_run) else $error("Mode not run without select."); // [R10]

  // A mask write stores the low status bits of the written word.
  property p_mask_write;
    @(posedge clock) disable iff (!rst_n)
      (writeAccess && hitMask) |=> state.intMask == $past(apbReq.pwdata[SPCG_INT_WIDTH-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("Mask write not stored.");

  // Main scenarios.
  c_sleep_write: cover property (@(posedge clock) disable iff (!rst_n) accessPhase && apbReq.pwrite && hitSleep);
  c_fault: cover property (@(posedge clock) disable iff (!rst_n) portBusFault ##1 irq);
  c_sleep_mode: cover property (@(posedge clock) disable iff (!rst_n) state.mode == SPCG_MODE_SLEEP);
  c_deep_mode: cover property (@(posedge clock) disable iff (!rst_n) state.mode == SPCG_MODE_DEEP);
  c_no_select_sleep: cover property (@(posedge clock) disable iff (!rst_n) !autoSleepGatingSelect && inSleep);

endmodule
`default_nettype wire

/* verification/spcg_sleep_gates_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module spcg_sleep_gates_tb import spcg_pkg::*;;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clock;
  logic rst_n;
  spcg_apb_req_t apbReq;
  spcg_apb_rsp_t apbRsp;
  logic inSleep;
  logic inDeepSleep;
  logic autoSleepGatingSelect;
  logic [7:0] runPortClockGates;
  logic [7:0] deepSleepPortClockGates;
  logic portAccess;
  logic [2:0] portIndex;
  logic portBusFault;
  logic portGrant;
  logic [7:0] portClockEnable;
  logic irq;
  int failures;
  int compares;

  // The block under test.
  spcg_sleep_gates u_spcg_sleep_gates (.clock(clock), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .inSleep(inSleep), .inDeepSleep(inDeepSleep), .autoSleepGatingSelect(autoSleepGatingSelect),
    .runPortClockGates(runPortClockGates), .deepSleepPortClockGates(deepSleepPortClockGates),
    .portAccess(portAccess), .portIndex(portIndex), .portBusFault(portBusFault), .portGrant(portGrant),
    .portClockEnable(portClockEnable), .irq(irq));

  // The clock toggles every half period of 5 ns.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [31:0] expected, input logic [31:0] seen);
    compares++;
    if (seen !== expected) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, expected, seen);
    end
  endtask

  // One APB transfer, entered just after a rising edge; it waits for pready.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
    @(posedge clock);
  endtask

  // A register write whose response is not examined.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  // A register read that must succeed with the expected word.
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(nm, exp, r);
    check("read error", 32'h0000_0000, {31'h0000_0000, e});
  endtask

  // Sets the power state and lets the applied set settle.
  task automatic setMode(input logic sel, input logic sl, input logic dp);
    autoSleepGatingSelect <= sel;
    inSleep <= sl;
    inDeepSleep <= dp;
    repeat (2) @(posedge clock);
  endtask

  // Holds reset low for two cycles, then releases it.
  task automatic doReset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Registers and enables start cleared.
  task automatic testReset();
    check("enables", 32'h0000_0000, {24'h00_0000, portClockEnable});
    check("irq", 32'h0000_0000, {31'h0000_0000, irq});
    rdchk(12'h118, 32'h0000_0000, "sleep gates");
    rdchk(12'h204, 32'h0000_0000, "int mask");
  endtask

  // Each port bit stores alone; reserved bits stay zero.
  task automatic testRegs();
    for (int i = 0; i < 8; i++) begin
      wr(12'h118, 32'hFFFF_FF00 | (32'h0000_0001 << i));
      rdchk(12'h118, 32'h0000_0001 << i, "walking gate");
    end
    wr(12'h118, 32'hFFFF_FFA5);
    rdchk(12'h118, 32'h0000_00A5, "gates");
  endtask

  // The applied set follows the power state and the select bit.
  task automatic testSelect();
    runPortClockGates <= 8'h3C;
    deepSleepPortClockGates <= 8'hC3;
    setMode(1'b1, 1'b1, 1'b0);
    check("sleep set", 32'h0000_00A5, {24'h00_0000, portClockEnable});
    rdchk(12'h208, 32'h0000_05A5, "sleep status");
    setMode(1'b1, 1'b1, 1'b1);
    check("deep set", 32'h0000_00C3, {24'h00_0000, portClockEnable});
    rdchk(12'h208, 32'h0000_06C3, "deep status");
    setMode(1'b1, 1'b0, 1'b0);
    check("run set", 32'h0000_003C, {24'h00_0000, portClockEnable});
    setMode(1'b0, 1'b1, 1'b0);
    check("no select", 32'h0000_003C, {24'h00_0000, portClockEnable});
    rdchk(12'h208, 32'h0000_003C, "no select status");
  endtask

  // Every port is granted when clocked and faulted when gated off.
  task automatic testFault();
    for (int i = 0; i < 8; i++) begin
      portAccess <= 1'b1;
      portIndex <= i[2:0];
      @(posedge clock);
      check("fault", {31'h0000_0000, ~runPortClockGates[i]}, {31'h0000_0000, portBusFault});
      check("grant", {31'h0000_0000, runPortClockGates[i]}, {31'h0000_0000, portGrant});
    end
    portAccess <= 1'b0;
    @(posedge clock);
  endtask

  // An unmasked fault raises the interrupt, then an unmasked gate change; a one clears each status.
  task automatic testIrq();
    wr(12'h204, 32'h0000_0001);
    wr(12'h200, 32'h0000_0003);
    portAccess <= 1'b1;
    portIndex <= 3'h0;
    @(posedge clock);
    portAccess <= 1'b0;
    @(posedge clock);
    check("irq set", 32'h0000_0001, {31'h0000_0000, irq});
    rdchk(12'h200, 32'h0000_0001, "fault status");
    wr(12'h200, 32'h0000_0001);
    check("irq clear", 32'h0000_0000, {31'h0000_0000, irq});
    wr(12'h204, 32'h0000_0002);
    runPortClockGates <= 8'h0F;
    repeat (2) @(posedge clock);
    check("irq change", 32'h0000_0001, {31'h0000_0000, irq});
    rdchk(12'h200, 32'h0000_0002, "change status");
    wr(12'h200, 32'h0000_0002);
  endtask

  // Unmapped and misaligned accesses are refused and change nothing.
  task automatic testRefused();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h11C, 32'h0000_0000, r, e);
    check("unmapped error", 32'h0000_0001, {31'h0000_0000, e});
    check("unmapped data", 32'h0000_0000, r);
    apb(1'b1, 12'h119, 32'h0000_00FF, r, e);
    check("misaligned error", 32'h0000_0001, {31'h0000_0000, e});
    rdchk(12'h118, 32'h0000_00A5, "gates kept");
  endtask

  // Software clears one gate by read-modify-write, writing reserved bits back as read.
  task automatic testRmw();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h118, 32'h0000_0000, r, e);
    apb(1'b1, 12'h118, r & ~32'h0000_0020, r, e);
    rdchk(12'h118, 32'h0000_0085, "rmw gates");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  // Drives every input at time zero, then runs the scenarios.
  initial begin
    failures = 0;
    compares = 0;
    rst_n = 1'b0;
    apbReq = '0;
    inSleep = 1'b0;
    inDeepSleep = 1'b0;
    autoSleepGatingSelect = 1'b0;
    runPortClockGates = 8'h00;
    deepSleepPortClockGates = 8'h00;
    portAccess = 1'b0;
    portIndex = 3'h0;
    doReset();
    @(posedge clock);
    testReset();
    testRegs();
    testSelect();
    testFault();
    testIrq();
    testRefused();
    testRmw();
    runPortClockGates <= 8'h00;
    doReset();
    @(posedge clock);
    testReset();
    stop_test();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
